// >>> design/ledfc_pkg.sv
// package of constants and types for the led driver feature control block
package ledfc_pkg;
  // ****************************************
  // command decode
  // ****************************************
  localparam int FRAME_W = 16;
  localparam logic [3:0] ADDR_NOOP = 4'h0;
  localparam logic [3:0] ADDR_FEATURE = 4'hE;
  localparam logic [7:0] FEATURE_RST = 8'h00;
  // ****************************************
  // feature field positions
  // ****************************************
  localparam int BIT_CLK_EXT = 0;
  localparam int BIT_SOFT_RESET = 1;
  localparam int BIT_FONT_HEX = 2;
  localparam int BIT_UNUSED = 3;
  localparam int BIT_BLINK_EN = 4;
  localparam int BIT_BLINK_SLOW = 5;
  localparam int BIT_SYNC = 6;
  localparam int BIT_BLINK_START = 7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int BLINK_FAST_HALF_MS = 500;
  localparam int BLINK_SLOW_HALF_MS = 1000;
  localparam int BLINK_FAST_CYC = BLINK_FAST_HALF_MS * CLK_MHZ * 1000;
  localparam int BLINK_SLOW_CYC = BLINK_SLOW_HALF_MS * CLK_MHZ * 1000;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic blink_start;
    logic sync;
    logic blink_slow;
    logic blink_en;
    logic unused_bit;
    logic font_hex;
    logic soft_reset;
    logic clk_ext;
  } ledfc_feature_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ledfc_frame_t;
  typedef enum logic {
    PH_OFF = 1'b0,
    PH_ON = 1'b1
  } ledfc_phase_t;
endpackage : ledfc_pkg

// >>> design/ledfc_top.sv
// serial command link and feature control register of the led driver
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - feature register is all zero after power-up reset.
// - any command whose low address nibble is E writes the feature register.
// - bit 0 selects system clock: internal oscillator or serial clock pin.
// - writing bit 1 as one resets all other control registers.
// - soft reset leaves digit data registers untouched.
// - bit 2 selects decode font: zero bcd, one hexadecimal.
// - bit 4 turns blinking on or off.
// - bit 5 picks blink period one or two seconds.
// - with bit 6 set, load rising edge clears blink timing counter.
// - bit 7 picks first blink phase: zero off, one on.
// - low address nibble zero is a noop_command and writes no register; with bit 6 set its load edge still clears the blink timer.
// - load rising edge latches shift register and executes the command.
module ledfc_top
  import ledfc_pkg::*;
#(
  parameter int unsigned BLINK_FAST_CYCLES = BLINK_FAST_CYC,
  parameter int unsigned BLINK_SLOW_CYCLES = BLINK_SLOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic load_strobe_i,
  output logic serial_out_o,
  output ledfc_feature_t feature_o,
  output logic sys_clk_ext_o,
  output logic font_hex_o,
  output logic soft_reset_o,
  output logic display_on_o,
  output logic cmd_valid_o,
  output ledfc_frame_t cmd_o
);
  // ****************************************
  // link domain shift register
  // ****************************************
  logic [FRAME_W-1:0] shift_q;
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[FRAME_W-2:0], serial_in_i};
    end
  end
  // msb out, so a cascade passes each bit on after a full frame
  assign serial_out_o = shift_q[FRAME_W-1];

  // link edges since reset, saturating at one frame; the delay check waits for it
  logic [4:0] shift_fill_q;
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_fill_q <= 5'h00;
    end else if (shift_fill_q != 5'(FRAME_W)) begin
      shift_fill_q <= shift_fill_q + 5'h01;
    end
  end

  // ****************************************
  // decode helpers
  // ****************************************
  // only the low nibble decodes, so the upper nibble is free for the host
  function automatic logic is_feature_addr(input logic [7:0] addr);
    return addr[3:0] == ADDR_FEATURE;
  endfunction : is_feature_addr
  function automatic logic is_noop_addr(input logic [7:0] addr);
    return addr[3:0] == ADDR_NOOP;
  endfunction : is_noop_addr
  // last count of a half period; shared by the timer and its check
  function automatic logic [31:0] last_count(input logic [31:0] half);
    return half - 32'h0000_0001;
  endfunction : last_count

  // ****************************************
  // synchronisers into the system domain
  // ****************************************
  logic ld_m_q, ld_s_q, ld_d_q;
  logic sc_m_q, sc_s_q, sc_d_q;
  // load pin: two flops against metastability, the third only marks the edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ld_m_q <= 1'b0;
      ld_s_q <= 1'b0;
      ld_d_q <= 1'b0;
    end else begin
      ld_m_q <= load_strobe_i;
      ld_s_q <= ld_m_q;
      ld_d_q <= ld_s_q;
    end
  end
  // serial clock sampled as data: paces the blink timer on the external clock
  // limitation: link clock must stay well below half the system clock rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sc_m_q <= 1'b0;
      sc_s_q <= 1'b0;
      sc_d_q <= 1'b0;
    end else begin
      sc_m_q <= sclk_i;
      sc_s_q <= sc_m_q;
      sc_d_q <= sc_s_q;
    end
  end
  logic ld_rise;
  logic sc_rise;
  assign ld_rise = ld_s_q & ~ld_d_q;
  assign sc_rise = sc_s_q & ~sc_d_q;

  // ****************************************
  // command decode
  // ****************************************
  // shift_q is read only on the synced load edge: the host holds the
  // serial clock still around load, so the word is stable by then
  ledfc_frame_t frame;
  logic wr_feature;
  logic wr_other;
  assign frame = shift_q;
  assign wr_feature = ld_rise && is_feature_addr(frame.addr);
  assign wr_other = ld_rise && !is_feature_addr(frame.addr)
                    && !is_noop_addr(frame.addr);

  ledfc_feature_t feat_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feat_q <= ledfc_feature_t'(FEATURE_RST);
    end else if (wr_feature) begin
      feat_q <= ledfc_feature_t'(frame.data);
    end
  end
  assign feature_o = feat_q;
  assign sys_clk_ext_o = feat_q.clk_ext;
  assign font_hex_o = feat_q.font_hex;

  // soft reset reaches control registers only; digit data has no reset input here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= wr_feature && frame.data[BIT_SOFT_RESET];
    end
  end

  // other registers live outside; hand them the executed command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
    end else begin
      cmd_valid_o <= wr_other;
      if (wr_other) begin
        cmd_o <= frame;
      end
    end
  end

  // ****************************************
  // blink timing
  // ****************************************
  logic [31:0] cnt_q;
  logic [31:0] half_cyc;
  logic tick;
  logic clr;
  logic en_d_q;
  ledfc_phase_t phase_q;
  // on the external clock the timer counts serial clock edges instead
  assign half_cyc = feat_q.blink_slow ? BLINK_SLOW_CYCLES : BLINK_FAST_CYCLES;
  assign tick = feat_q.clk_ext ? sc_rise : 1'b1;
  assign clr = !feat_q.blink_en || !en_d_q || (feat_q.sync && ld_rise);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_d_q <= 1'b0;
    end else begin
      en_d_q <= feat_q.blink_en;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      phase_q <= PH_OFF;
    end else if (clr) begin
      cnt_q <= '0;
      phase_q <= feat_q.blink_start ? PH_ON : PH_OFF;
    end else if (tick) begin
      // >= so a shorter period chosen mid-count still wraps at once
      if (cnt_q >= last_count(half_cyc)) begin
        cnt_q <= '0;
        unique case (phase_q)
          PH_OFF: phase_q <= PH_ON;
          PH_ON: phase_q <= PH_OFF;
        endcase
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
  assign display_on_o = !feat_q.blink_en || (en_d_q && phase_q == PH_ON);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  feat_reset_a: assert property (disable iff (1'b0)
    !rst_n_i |-> feat_q == ledfc_feature_t'(FEATURE_RST))
    else $error("feature register not zero in reset");
  feat_write_a: assert property (wr_feature |=> feat_q == $past(frame.data)
    && sys_clk_ext_o == $past(frame.data[BIT_CLK_EXT])
    && font_hex_o == $past(frame.data[BIT_FONT_HEX]))
    else $error("feature write not applied");
  noop_hold_a: assert property (ld_rise && is_noop_addr(frame.addr)
    |=> $stable(feat_q) && !cmd_valid_o && !soft_reset_o)
    else $error("noop_command changed state");
  soft_rst_a: assert property (soft_reset_o
    |-> $past(wr_feature) && $past(frame.data[BIT_SOFT_RESET]))
    else $error("soft reset without cause");
  soft_fire_a: assert property (wr_feature && frame.data[BIT_SOFT_RESET]
    |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  cmd_exec_a: assert property (wr_other |=> cmd_valid_o && cmd_o == $past(frame))
    else $error("command not passed on");
  blink_off_a: assert property (!feat_q.blink_en |-> display_on_o)
    else $error("display dark with blinking off");
  sync_clr_a: assert property (feat_q.blink_en && en_d_q && feat_q.sync && ld_rise
    |=> cnt_q == 32'h0000_0000 && phase_q == ledfc_phase_t'($past(feat_q.blink_start)))
    else $error("load edge did not clear blink timer");
  blink_start_a: assert property ($rose(feat_q.blink_en) ##1 1'b1
    |-> phase_q == ledfc_phase_t'(feat_q.blink_start))
    else $error("blink started in wrong phase");
  blink_flip_a: assert property (!clr && tick && cnt_q == last_count(half_cyc)
    |=> phase_q != $past(phase_q) && cnt_q == 32'h0000_0000)
    else $error("blink phase did not flip at half period");
  shift_out_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
    shift_fill_q == 5'(FRAME_W) |-> serial_out_o == $past(serial_in_i, 16))
    else $error("serial out not delayed one frame");

  // ****************************************
  // command checks
  // ****************************************
  feat_keep_a: assert property (ld_rise && !is_feature_addr(frame.addr)
    |=> $stable(feat_q))
    else $error("feature register changed by another command");
  feat_steady_a: assert property (!wr_feature |=> $stable(feat_q))
    else $error("feature register changed without a write");
  cmd_idle_a: assert property (!wr_other
    |=> !cmd_valid_o && $stable(cmd_o))
    else $error("command passed on without a load");
  cmd_hold_a: assert property (!cmd_valid_o |-> $stable(cmd_o))
    else $error("command output moved without valid");
  cmd_once_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command valid longer than one cycle");

  soft_digit_a: assert property (soft_reset_o |-> $stable(cmd_o))
    else $error("soft reset disturbed digit command");
  soft_once_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset longer than one cycle");
  soft_quiet_a: assert property (wr_feature && !frame.data[BIT_SOFT_RESET]
    |=> !soft_reset_o)
    else $error("soft reset fired on a zero bit");

  // ****************************************
  // blink checks
  // ****************************************
  blink_dark_a: assert property (feat_q.blink_en && en_d_q && phase_q == PH_OFF
    |-> !display_on_o)
    else $error("display lit in off phase");
  blink_lit_a: assert property (feat_q.blink_en && en_d_q && phase_q == PH_ON
    |-> display_on_o)
    else $error("display dark in on phase");
  start_dark_a: assert property ($rose(feat_q.blink_en) |-> !display_on_o)
    else $error("display lit in blink enable cycle");
  ext_hold_a: assert property (feat_q.clk_ext && !clr && !sc_rise
    |=> $stable(cnt_q) && $stable(phase_q))
    else $error("blink timer moved without a link clock edge");
  int_count_a: assert property (!feat_q.clk_ext && !clr
    |=> $changed(cnt_q) || $changed(phase_q))
    else $error("blink timer stalled on internal clock");
  cnt_range_a: assert property (feat_q.blink_en |-> cnt_q < BLINK_SLOW_CYCLES)
    else $error("blink counter beyond slow half period");

  // ****************************************
  // covers
  // ****************************************
  feat_write_c: cover property (wr_feature && frame.data[BIT_BLINK_EN]);
  noop_c: cover property (ld_rise && is_noop_addr(frame.addr));
  ext_blink_c: cover property (feat_q.clk_ext && feat_q.blink_en && sc_rise);
  blink_flip_c: cover property (feat_q.blink_en && $changed(phase_q));
  sync_c: cover property (feat_q.sync && ld_rise && feat_q.blink_en);
endmodule : ledfc_top
`default_nettype wire

// >>> tb/led_driver_feature_control_bench.sv
// self-checking bench of the feature control block
`timescale 1ns/1ps
`default_nettype none
module led_driver_feature_control_bench
  import ledfc_pkg::*;
  ;
  typedef struct packed {ledfc_frame_t f; logic [7:0] feat; logic [1:0] pl;} ledfc_row_t;
  ledfc_row_t rows [7] = '{'{16'h0E04, 8'h04, 2'b00}, '{16'hFE01, 8'h01, 2'b00},
    '{16'h3E02, 8'h02, 2'b10}, '{16'h0E02, 8'h02, 2'b10}, '{16'h5000, 8'h02, 2'b00},
    '{16'h0135, 8'h02, 2'b01}, '{16'h0E00, 8'h00, 2'b00}};
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic sclk, serial_in, load, so, ext, font, srst, disp, cv;
  ledfc_feature_t feat;
  ledfc_frame_t cmd;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_sr = 0;
  int n_cv = 0;
  int n;
  always #4 clk = ~clk;
  ledfc_host host (.so_i(so), .sclk_o(sclk), .sdi_o(serial_in), .load_o(load));
  ledfc_top #(.BLINK_FAST_CYCLES(20), .BLINK_SLOW_CYCLES(40)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .serial_in_i(serial_in), .load_strobe_i(load),
    .serial_out_o(so), .feature_o(feat), .sys_clk_ext_o(ext), .font_hex_o(font),
    .soft_reset_o(srst), .display_on_o(disp), .cmd_valid_o(cv), .cmd_o(cmd));
  // pulses are counted, not sampled, since their cycle jitters by one
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (srst === 1'b1) n_sr <= n_sr + 1;
    if (cv === 1'b1) n_cv <= n_cv + 1;
    if (cycles == 8000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic frame(input ledfc_frame_t f);
    @(negedge clk);
    #1 host.shift(f);
    host.load();
  endtask : frame
  task automatic hi_len(output int k);
    k = 0;
    while (disp !== 1'b0) @(negedge clk);
    while (disp !== 1'b1) @(negedge clk);
    while (disp === 1'b1) begin
      @(negedge clk);
      k++;
    end
  endtask : hi_len
  task automatic summarize();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(feat), 16'h0000, "reset feat");
    chk(16'(disp), 16'h0001, "reset disp");
    foreach (rows[i]) begin
      n_sr = 0;
      n_cv = 0;
      frame(rows[i].f);
      chk(16'(feat), 16'(rows[i].feat), "feat");
      chk(16'(ext), 16'(rows[i].feat[0]), "clk src");
      chk(16'(font), 16'(rows[i].feat[2]), "font");
      chk(16'(n_sr), 16'(rows[i].pl[1]), "soft rst");
      chk(16'(n_cv), 16'(rows[i].pl[0]), "cmd valid");
      if (rows[i].pl[0]) chk(cmd, rows[i].f, "cmd");
    end
    $display("rows done");
    frame(16'h0E90);
    hi_len(n);
    chk(16'(n), 16'd20, "fast half");
    frame(16'h0EB0);
    hi_len(n);
    chk(16'(n), 16'd40, "slow half");
    frame(16'h0ED0);
    frame(16'h0000);
    chk(16'(disp), 16'h0001, "start on");
    frame(16'h0E50);
    frame(16'h0000);
    chk(16'(disp), 16'h0000, "start off");
    frame(16'h0E00);
    chk(16'(disp), 16'h0001, "blink off");
    $display("blink done");
    @(negedge clk);
    #1 host.shift(16'h0E04);
    host.shift(16'h0000);
    host.load();
    chk(host.rx, 16'h0E04, "chain out");
    chk(16'(feat), 16'h0000, "noop last");
    $display("chain done");
    frame(16'h0E85);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(feat), 16'h0000, "mid reset");
    rst_n <= 1'b1;
    $display("reset done");
    summarize();
  end
endmodule : led_driver_feature_control_bench
`default_nettype wire

// >>> tb/ledfc_host.sv
// host model driving the three-wire command link
`timescale 1ns/1ps
`default_nettype none
module ledfc_host
  import ledfc_pkg::*;
(
  input wire logic so_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic load_o
);
  ledfc_frame_t rx = 16'h0000;
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    load_o = 1'b0;
  end
  // msb first, 80 ns link clock, still between frames
  task automatic shift(input ledfc_frame_t f);
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      #40 sclk_o = 1'b0;
      sdi_o = f[i];
      #40 rx = {rx[14:0], so_i};
      sclk_o = 1'b1;
    end
    #40 sclk_o = 1'b0;
    sdi_o = ~f[0];
  endtask : shift
  // link stays still while load is high, long enough for the sync
  task automatic load();
    #40 load_o = 1'b1;
    #96 load_o = 1'b0;
  endtask : load
endmodule : ledfc_host
`default_nettype wire
